// *** logic/wdog_power.sv ***
// Watchdog, halt/stop control and oscillator warm-up timer.
// Assumes the processor gives one-cycle halt/stop pulses and an oscillator tick.
`timescale 1ns/1ps
`include "wdog_cfg.svh"
module wdog_power
   import wdog_pkg::*;
(
   // Clock and power-on reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Register port
   input  wire logic [4:0] reg_addr,
   input  wire logic [3:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [3:0] reg_rdata,
   // Mask-time options and pins
   input  wire logic       wdog_enable_option,
   input  wire logic [1:0] clock_source_option,
   input  wire logic       pad_reset_pin,
   input  wire logic       osc_tick,
   // Processor side
   input  wire logic       halt_req,
   input  wire logic       stop_req,
   input  wire logic       irq_any,
   input  wire logic       irq_stop_wake,
   // Status outputs
   output logic            device_reset,
   output logic            cpu_run,
   output logic            osc_run,
   output logic            periph_run,
   output logic            wake_irq,
   output logic [2:0]      timer0_mode_field
);

   ////////////////////////////////////////////////////////////////////////
   // Pad reset synchroniser: three stages, level follows when 2 and 3 agree
   logic [2:0] pad_sync;
   logic       pad_level;
   logic       next_pad_level;

   always_comb begin
      next_pad_level = pad_level;
      if (pad_sync[1] == pad_sync[2]) begin
         next_pad_level = pad_sync[2];
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pad_sync  <= 3'h0;
         pad_level <= 1'b0;
      end else begin
         pad_sync  <= {pad_sync[1:0], pad_reset_pin};
         pad_level <= next_pad_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Prescaler ratio as a count of base periods
   function automatic logic [10:0] ratio_of(input logic [2:0] code);
      case (code)
         3'h7:    ratio_of = 11'h001;
         3'h6:    ratio_of = 11'h002;
         3'h5:    ratio_of = 11'h004;
         3'h4:    ratio_of = 11'h008;
         3'h3:    ratio_of = 11'h020;
         3'h2:    ratio_of = 11'h080;
         3'h1:    ratio_of = 11'h200;
         default: ratio_of = 11'h400;
      endcase
   endfunction : ratio_of

   // Warm-up length for an event, by clock option
   function automatic logic [14:0] warm_of(input logic [1:0] kind, input logic xtal);
      case (kind)
         2'h0:    warm_of = xtal ? `WARM_POR_XTAL : `WARM_POR_RC;
         2'h1:    warm_of = xtal ? `WARM_PAD_XTAL : `WARM_PAD_RC;
         default: warm_of = xtal ? `WARM_STOP_XTAL : `WARM_STOP_RC;
      endcase
   endfunction : warm_of

   localparam logic [14:0] BASE_CYC = 15'(`BASE_TIMEOUT_CYC);

   ////////////////////////////////////////////////////////////////////////
   // Main state: mode, warm-up, watchdog counters, flag, prescaler field
   power_mode_t mode;
   power_mode_t next_mode;
   logic [14:0] warm_cnt;
   logic [14:0] next_warm_cnt;
   logic [14:0] base_cnt;
   logic [14:0] next_base_cnt;
   logic [10:0] wdog_cnt;
   logic [10:0] next_wdog_cnt;
   logic        wdog_restart_flag;
   logic        next_wdog_restart_flag;
   logic [3:0]  timer0_mode_reg;
   logic [3:0]  next_timer0_mode_reg;
   logic        pad_prev;
   logic        dev_rst;
   logic        next_dev_rst;
   logic        wake_q;
   logic        next_wake_q;
   logic [3:0]  rdata;
   logic [3:0]  next_rdata;
   logic        xtal;
   logic        wd_on;
   logic        pad_edge;
   logic        wr_restart;
   logic        wr_t0m;
   logic        por_seen;

   assign xtal       = (clock_source_option == `CLK_OPT_XTAL);
   assign wd_on      = wdog_enable_option;
   assign pad_edge   = pad_level & ~pad_prev;
   assign wr_restart = reg_wr && (reg_addr == `ADDR_WDOG_RESTART)
                       && reg_wdata[`BIT_WDOG_FLAG];
   assign wr_t0m     = reg_wr && (reg_addr == `ADDR_TIMER0_MODE);

   always_comb begin
      next_mode              = mode;
      next_warm_cnt          = warm_cnt;
      next_base_cnt          = base_cnt;
      next_wdog_cnt          = wdog_cnt;
      next_wdog_restart_flag = wdog_restart_flag;
      next_timer0_mode_reg   = timer0_mode_reg;
      next_dev_rst           = 1'b0;
      next_wake_q            = 1'b0;
      next_rdata             = 4'h0;
      // Register reads, data in the next cycle
      if (reg_rd) begin
         if (reg_addr == `ADDR_WDOG_RESTART) begin
            next_rdata = {wdog_restart_flag, 3'h0};
         end else if (reg_addr == `ADDR_TIMER0_MODE) begin
            next_rdata = timer0_mode_reg;
         end
      end
      if (wr_t0m) begin
         next_timer0_mode_reg = reg_wdata;
      end
      // First cycle after power-on: option is now readable, pick its warm-up
      if (!por_seen) begin
         next_warm_cnt = warm_of(2'h0, xtal);
      end
      if (pad_edge) begin
         // Pad reset: reload warm-up, clear counter, flag set
         next_mode              = mode_warm;
         next_warm_cnt          = warm_of(2'h1, xtal);
         next_wdog_restart_flag = 1'b1;
         next_timer0_mode_reg   = `RESET_TIMER0_MODE;
         next_base_cnt          = 15'h0;
         next_wdog_cnt          = 11'h0;
         next_dev_rst           = 1'b1;
      end else begin
         case (mode)
            mode_warm: begin
               if (osc_tick) begin
                  if (warm_cnt <= 15'h1) begin
                     next_mode = mode_run;
                  end else begin
                     next_warm_cnt = warm_cnt - 15'h1;
                  end
               end
            end
            mode_run: begin
               if (stop_req) begin
                  next_mode = mode_stop;
               end else if (halt_req) begin
                  next_mode = mode_halt;
               end
            end
            mode_halt: begin
               if (irq_any) begin
                  next_mode   = mode_run;
                  next_wake_q = 1'b1;
               end
            end
            mode_stop: begin
               if (irq_stop_wake) begin
                  next_mode              = mode_warm;
                  next_warm_cnt          = warm_of(2'h2, xtal);
                  next_wdog_restart_flag = 1'b1;
                  next_base_cnt          = 15'h0;
                  next_wdog_cnt          = 11'h0;
                  next_wake_q            = 1'b1;
               end
            end
            default: next_mode = mode_warm;
         endcase
         // Watchdog counts down on the system clock, not in stop or warm-up
         if (wd_on && (mode == mode_run || mode == mode_halt)) begin
            if (wr_restart) begin
               next_base_cnt = 15'h0;
               next_wdog_cnt = 11'h0;
            end else if (base_cnt == 15'h0) begin
               next_base_cnt = BASE_CYC - 15'h1;
               if (wdog_cnt == 11'h0) begin
                  next_wdog_cnt = ratio_of(timer0_mode_reg[2:0]);
               end else if (wdog_cnt == 11'h1) begin
                  // Underflow: device reset, flag cleared
                  next_dev_rst           = 1'b1;
                  next_wdog_restart_flag = 1'b0;
                  next_timer0_mode_reg   = `RESET_TIMER0_MODE;
                  next_wdog_cnt          = 11'h0;
                  next_mode              = mode_run;
               end else begin
                  next_wdog_cnt = wdog_cnt - 11'h1;
               end
            end else begin
               next_base_cnt = base_cnt - 15'h1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mode              <= mode_warm;
         warm_cnt          <= `WARM_POR_RC;
         base_cnt          <= 15'h0;
         wdog_cnt          <= 11'h0;
         wdog_restart_flag <= 1'b1;
         timer0_mode_reg   <= `RESET_TIMER0_MODE;
         pad_prev          <= 1'b0;
         dev_rst           <= 1'b0;
         wake_q            <= 1'b0;
         rdata             <= 4'h0;
      end else begin
         mode              <= next_mode;
         warm_cnt          <= next_warm_cnt;
         base_cnt          <= next_base_cnt;
         wdog_cnt          <= next_wdog_cnt;
         wdog_restart_flag <= next_wdog_restart_flag;
         timer0_mode_reg   <= next_timer0_mode_reg;
         pad_prev          <= pad_level;
         dev_rst           <= next_dev_rst;
         wake_q            <= next_wake_q;
         rdata             <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-on warm-up length follows the option only if osc_tick is low in the first cycle after release
   logic next_por_seen;

   always_comb begin
      next_por_seen = 1'b1;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         por_seen <= 1'b0;
      end else begin
         por_seen <= next_por_seen;
      end
   end

   // Registered outputs
   logic [4:0] out_q;
   logic [4:0] next_out_q;

   always_comb begin
      next_out_q[0] = next_dev_rst;
      next_out_q[1] = (next_mode == mode_run);
      next_out_q[2] = (next_mode != mode_stop);
      next_out_q[3] = (next_mode != mode_stop);
      next_out_q[4] = next_wake_q;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         out_q <= 5'h0C;
      end else begin
         out_q <= next_out_q;
      end
   end

   assign device_reset      = out_q[0];
   assign cpu_run           = out_q[1];
   assign osc_run           = out_q[2];
   assign periph_run        = out_q[3];
   assign wake_irq          = out_q[4];
   assign reg_rdata         = rdata;
   assign timer0_mode_field = timer0_mode_reg[2:0];

endmodule : wdog_power

// *** logic/wdog_cfg.svh ***
// Constants for the watchdog, power-mode and warm-up block.
// Assumes a 50 MHz core clock; the oscillator rate arrives as a one-cycle tick.
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH
`define ADDR_TIMER0_MODE   5'h02
`define ADDR_WDOG_RESTART  5'h1A
`define BIT_WDOG_FLAG      3
`define RESET_TIMER0_MODE  4'h0
`define WARM_POR_RC        15'h1000
`define WARM_POR_XTAL      15'h4000
`define WARM_PAD_RC        15'h0100
`define WARM_PAD_XTAL      15'h0400
`define WARM_STOP_RC       15'h0100
`define WARM_STOP_XTAL     15'h4000
`define BASE_TIMEOUT_US    500
`define CORE_CLK_MHZ       50
`define BASE_TIMEOUT_CYC   ((`BASE_TIMEOUT_US) * (`CORE_CLK_MHZ))
`define CLK_OPT_XTAL       2'h0
`endif

// *** logic/wdog_pkg.sv ***
// Types for the watchdog block.
// Assumes nothing beyond the constants header.
package wdog_pkg;
   typedef enum logic [1:0] {
      mode_warm,
      mode_run,
      mode_halt,
      mode_stop
   } power_mode_t;
endpackage : wdog_pkg

// *** test/wdog_power_sva.sv ***
// Checker for the watchdog, halt/stop and warm-up block.
// Assumes it is bound to wdog_power and sees only its ports.
`timescale 1ns/1ps
module wdog_power_sva (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // Register port
   input wire logic       reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [3:0] reg_rdata,
   // Options, pins and processor side
   input wire logic       wdog_enable_option,
   input wire logic       pad_reset_pin,
   input wire logic       halt_req,
   input wire logic       stop_req,
   input wire logic       irq_stop_wake,
   // Status
   input wire logic       device_reset,
   input wire logic       cpu_run,
   input wire logic       osc_run,
   input wire logic       periph_run,
   input wire logic       wake_irq,
   input wire logic [2:0] timer0_mode_field
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic [3:0] pad_age;
   logic [3:0] next_pad_age;
   // Cycles since the pad pin was last high, saturating
   always_comb begin
      next_pad_age = pad_age;
      if (pad_reset_pin) next_pad_age = 4'h0;
      else if (pad_age != 4'hF) next_pad_age = pad_age + 4'h1;
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) pad_age <= 4'hF;
      else pad_age <= next_pad_age;
   end
   ////////////////////////////////////////
   flag_bits_a: assert property (
      $past(reg_rd && reg_addr == 5'h1A) |-> reg_rdata[2:0] == 3'h0) else $error("flag spare bits");
   reset_pulse_a: assert property (
      device_reset |=> !device_reset) else $error("reset pulse too long");
   wake_pulse_a: assert property (
      wake_irq |=> !wake_irq) else $error("wake pulse too long");
   halt_entry_a: assert property (
      halt_req && cpu_run |-> ##[1:2] (!cpu_run && periph_run)) else $error("halt entry");
   stop_entry_a: assert property (
      stop_req && cpu_run |-> ##[1:2] (!osc_run && !periph_run)) else $error("stop entry");
   stop_hold_a: assert property (
      !osc_run && !irq_stop_wake |=> !osc_run) else $error("stop left without wake");
   wdog_off_a: assert property (
      device_reset && !wdog_enable_option |-> pad_age < 4'h8) else $error("reset while off");
   field_init_a: assert property (
      $fell(reset) |-> timer0_mode_field == 3'h0) else $error("prescaler field not 000");
   stop_cpu_a: assert property (
      !osc_run |-> !cpu_run) else $error("cpu runs in stop");
endmodule : wdog_power_sva

// *** test/tb.sv ***
// Self-checking bench for the watchdog, halt/stop and warm-up block.
// Assumes a 50 MHz core clock and an oscillator tick on every cycle.
`timescale 1ns/1ps
module tb;
   logic       core_clk, reset, reg_wr, reg_rd, wdog_enable_option, pad_reset_pin;
   logic       osc_tick, halt_req, stop_req, irq_any, irq_stop_wake;
   logic       device_reset, cpu_run, osc_run, periph_run, wake_irq;
   logic [4:0] reg_addr;
   logic [3:0] reg_wdata, reg_rdata, d;
   logic [1:0] clock_source_option;
   logic [2:0] timer0_mode_field;
   int         miscompares, n_compared, cyc, resets, t0, n;
   // Register rows: address, write data, expected read data
   logic [12:0] rows [0:9] = '{{5'h02, 4'h7, 4'h7}, {5'h02, 4'h6, 4'h6}, {5'h02, 4'h5, 4'h5},
      {5'h02, 4'h4, 4'h4}, {5'h02, 4'hB, 4'hB}, {5'h02, 4'h2, 4'h2}, {5'h02, 4'h1, 4'h1},
      {5'h02, 4'h0, 4'h0}, {5'h05, 4'hF, 4'h0}, {5'h1A, 4'h0, 4'h8}};
   wdog_power dut (.*);
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Cycle and reset-pulse counters
   always @(posedge core_clk) begin
      cyc++;
      if (device_reset === 1'b1) resets++;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check
   task automatic complete_run();
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic wr(input logic [4:0] a, input logic [3:0] w);
      @(posedge core_clk);
      reg_addr <= a; reg_wdata <= w; reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [3:0] r);
      @(posedge core_clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask : rd
   // Wait for cpu_run (0), device_reset (1) or wake_irq (2)
   task automatic wait_sig(input int sel, input int lim, output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1 k++;
      end while (k < lim && (sel == 0 ? cpu_run : sel == 1 ? device_reset : wake_irq) !== 1'b1);
      check("wait bound", 1, k < lim);
   endtask : wait_sig
   ////////////////////////////////////////
   initial begin
      reset = 1'b1; reg_addr = 5'h00; reg_wdata = 4'h0; reg_wr = 1'b0; reg_rd = 1'b0;
      wdog_enable_option = 1'b1; clock_source_option = 2'h2; pad_reset_pin = 1'b0;
      osc_tick = 1'b1; halt_req = 1'b0; stop_req = 1'b0; irq_any = 1'b0; irq_stop_wake = 1'b0;
      repeat (16) @(posedge core_clk);
      #1 check("field in reset", 0, timer0_mode_field);
      check("reset out in reset", 0, {device_reset, wake_irq, cpu_run});
      @(posedge core_clk);
      reset <= 1'b0; t0 = cyc;
      rd(5'h1A, d); check("flag after power-on", 8, d);
      wait_sig(0, 6000, n); check("power-on warm-up", 1, cyc - t0 >= 4096);
      $display("test power_on done");
      for (int i = 0; i < 10; i++) begin
         wr(rows[i][12:8], rows[i][7:4]);
         rd(rows[i][12:8], d); check("register read", rows[i][3:0], d);
         if (rows[i][12:8] == 5'h02) check("shared field", rows[i][6:4], timer0_mode_field);
      end
      $display("test registers done");
      wr(5'h02, 4'h7);
      repeat (2) begin
         repeat (20000) @(posedge core_clk);
         wr(5'h1A, 4'h8);
      end
      t0 = cyc;
      check("reset before time-out", 0, resets);
      wait_sig(1, 30000, n); check("time-out span", 1, cyc - t0 inside {[24990:25100]});
      rd(5'h1A, d); check("flag after time-out", 0, d);
      rd(5'h02, d); check("field after time-out", 0, d);
      wait_sig(0, 20000, n);
      $display("test watchdog done");
      @(posedge core_clk) halt_req <= 1'b1;
      @(posedge core_clk) halt_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1 check("halt run state", 2'b01, {cpu_run, periph_run});
      @(posedge core_clk) irq_any <= 1'b1;
      wait_sig(2, 20, n);
      wait_sig(0, 20, n);
      @(posedge core_clk) irq_any <= 1'b0;
      $display("test halt done");
      @(posedge core_clk) stop_req <= 1'b1;
      @(posedge core_clk) stop_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      irq_any <= 1'b1;
      repeat (50) @(posedge core_clk);
      #1 check("stop with other irq", 0, {osc_run, cpu_run});
      @(posedge core_clk) irq_stop_wake <= 1'b1;
      t0 = cyc;
      wait_sig(0, 2000, n); check("stop warm-up", 1, cyc - t0 >= 256);
      @(posedge core_clk) {irq_any, irq_stop_wake} <= 2'b00;
      rd(5'h1A, d); check("flag after stop", 8, d);
      $display("test stop done");
      @(posedge core_clk) {pad_reset_pin, wdog_enable_option} <= 2'b10;
      t0 = cyc; n = resets;
      repeat (8) @(posedge core_clk);
      pad_reset_pin <= 1'b0;
      check("pad reset pulses", n + 1, resets);
      wait_sig(0, 2000, n); check("pad warm-up", 1, cyc - t0 inside {[256:400]});
      rd(5'h1A, d); check("flag after pad", 8, d);
      $display("test pad_reset done");
      complete_run();
   end
   // Hang guard
   initial begin
      #1900000;
      miscompares++;
      complete_run();
   end
endmodule : tb
bind wdog_power wdog_power_sva chk (.core_clk(core_clk), .reset(reset), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_rdata(reg_rdata), .wdog_enable_option(wdog_enable_option),
   .pad_reset_pin(pad_reset_pin), .halt_req(halt_req), .stop_req(stop_req),
   .irq_stop_wake(irq_stop_wake), .device_reset(device_reset), .cpu_run(cpu_run),
   .osc_run(osc_run), .periph_run(periph_run), .wake_irq(wake_irq),
   .timer0_mode_field(timer0_mode_field));
